// ===== src/fps_params.svh
`ifndef FPS_PARAMS_SVH
`define FPS_PARAMS_SVH
// ----------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------
`define FPS_OFF_KEY     6'h00
`define FPS_OFF_PROT0   6'h04
`define FPS_OFF_PROT1   6'h08
`define FPS_OFF_SETUP   6'h0c
`define FPS_OFF_STATUS  6'h10
`define FPS_OFF_SSTART  6'h14
`define FPS_OFF_SEND    6'h18
`define FPS_OFF_SIG     6'h1c
`define FPS_OFF_CMD     6'h20
`define FPS_OFF_WADDR   6'h24
`define FPS_OFF_WDLO    6'h28
`define FPS_OFF_WDHI    6'h2c
// ----------------------------------------------------------------------
// values and fields
// ----------------------------------------------------------------------
`define FPS_USER_KEY    32'hf123f456
`define FPS_PROT_RST    32'hffffffff
`define FPS_PW_OFF      19'h7fff0
`define FPS_CRC_POLY    24'h800063
`define FPS_CRC_INIT    24'hffffff
`define FPS_KSIGN_START 20'h00000
`define FPS_KSIGN_END   20'h01fff
`define FPS_SETUP_RST   32'h00000001
`define FPS_SETUP_DBG   0
`define FPS_ST_BUSY     0
`define FPS_ST_DONE     1
`define FPS_ST_SFAIL    2
`define FPS_ST_ECOR     3
`define FPS_ST_EUNC     4
`define FPS_ST_FKEY     5
`define FPS_ST_FPROT    6
`define FPS_ST_FETCH    7
`endif

// ===== src/fps_pkg.sv
`default_nettype none
package fps_pkg;
   typedef enum logic [5:0] {
      ST_LD   = 6'h01,
      ST_IDLE = 6'h02,
      ST_SRD  = 6'h04,
      ST_SLO  = 6'h08,
      ST_SHI  = 6'h10,
      ST_OP   = 6'h20
   } fps_state_t;
   typedef enum logic [2:0] {
      CMD_NONE  = 3'h0,
      CMD_SIGN  = 3'h1,
      CMD_WRITE = 3'h2,
      CMD_EPAGE = 3'h3,
      CMD_EMASS = 3'h4
   } fps_cmd_t;
   typedef enum logic [1:0] {
      OP_READ  = 2'h0,
      OP_WRITE = 2'h1,
      OP_EPAGE = 2'h2,
      OP_EMASS = 2'h3
   } fps_op_t;
endpackage
`default_nettype wire

// ===== src/fps_top.sv
`timescale 1ns/100ps
`default_nettype none
`include "fps_params.svh"
module fps_top
(
   input  wire logic             i_clk,
   input  wire logic             i_arst_n,
   input  wire logic [5:0]       s_axi_awaddr,
   input  wire logic             s_axi_awvalid,
   output logic                  s_axi_awready,
   input  wire logic [31:0]      s_axi_wdata,
   input  wire logic [3:0]       s_axi_wstrb,
   input  wire logic             s_axi_wvalid,
   output logic                  s_axi_wready,
   output logic [1:0]            s_axi_bresp,
   output logic                  s_axi_bvalid,
   input  wire logic             s_axi_bready,
   input  wire logic [5:0]       s_axi_araddr,
   input  wire logic             s_axi_arvalid,
   output logic                  s_axi_arready,
   output logic [31:0]           s_axi_rdata,
   output logic [1:0]            s_axi_rresp,
   output logic                  s_axi_rvalid,
   input  wire logic             s_axi_rready,
   output logic                  o_fl_req,
   output fps_pkg::fps_op_t      o_fl_op,
   output logic [19:0]           o_fl_addr,
   output logic [63:0]           o_fl_wdata,
   input  wire logic             i_fl_ack,
   input  wire logic [63:0]      i_fl_rdata,
   input  wire logic             i_fl_ecc_corr,
   input  wire logic             i_fl_ecc_uncorr,
   output logic [1:0]            o_blk_stall,
   output logic                  o_fetch_err,
   input  wire logic             i_dbg_wr,
   input  wire logic [31:0]      i_dbg_rdata,
   output logic                  o_dbg_wr_en,
   output logic [31:0]           o_dbg_rdata
);
   import fps_pkg::*;

   // ------------------------------------------------------------------
   // reset release
   // ------------------------------------------------------------------
   logic [1:0] rst_sync_q;
   logic       rst_n;
   always_ff @(posedge i_clk or negedge i_arst_n)
      if (!i_arst_n)
         rst_sync_q <= 2'h0;
      else
         rst_sync_q <= {rst_sync_q[0], 1'b1};
   assign rst_n = rst_sync_q[1];

   // ------------------------------------------------------------------
   // crc step over one 32-bit half, bit 31 first
   // ------------------------------------------------------------------
   function automatic logic [23:0] crc_step(input logic [23:0] c,
                                            input logic [31:0] d);
      logic [23:0] r;
      logic        fb;
      r = c;
      for (int i = 31; i >= 0; i--)
      begin
         fb = r[23] ^ d[i];
         r  = {r[22:0], 1'b0} ^ (fb ? `FPS_CRC_POLY : 24'h000000);
      end
      return r;
   endfunction

   // ------------------------------------------------------------------
   // state
   // ------------------------------------------------------------------
   fps_state_t  st_q;
   logic        ld_blk_q, por_q, key_ok_q;
   logic        ecc_c_q, ecc_u_q;
   logic [1:0]  prog_q;
   logic [31:0] prot_q [2];
   logic [31:0] setup_q, sstart_q, send_q, waddr_q, status_q;
   logic [63:0] wdat_q, data_q;
   logic [23:0] crc_q, sig_q, crc_lo;
   logic [19:0] cur_q, last_q;
   logic        aw_ok_q, w_ok_q;
   logic [5:0]  wa_q;
   logic [31:0] wd_q;
   logic [3:0]  ws_q;

   // ------------------------------------------------------------------
   // bus write and command decode
   // ------------------------------------------------------------------
   logic       wr_fire, cmd_go, sgn, last_loc, fl_done, sign_end;
   logic       tgt_blk, grp_prot, is_pw, f_key, f_prot;
   logic [2:0] cmd_w;
   assign wr_fire  = aw_ok_q & w_ok_q & ~s_axi_bvalid & (ws_q == 4'hf);
   assign cmd_w    = wd_q[2:0];
   assign cmd_go   = wr_fire & (wa_q == `FPS_OFF_CMD) & (st_q == ST_IDLE)
                     & (cmd_w != CMD_NONE);
   assign tgt_blk  = waddr_q[19];
   assign grp_prot = ~prot_q[tgt_blk][waddr_q[18:14]];
   assign is_pw    = waddr_q[18:3] == `FPS_PW_OFF >> 3;
   assign f_key    = ~key_ok_q;
   always_comb
   begin
      case (cmd_w)
         CMD_WRITE: f_prot = grp_prot | (is_pw & prog_q[tgt_blk]);
         CMD_EPAGE: f_prot = grp_prot;
         default:   f_prot = 1'b0;
      endcase
   end
   assign sgn      = (st_q == ST_SRD) | (st_q == ST_SLO) | (st_q == ST_SHI);
   assign last_loc = cur_q[19:3] == last_q[19:3];
   assign fl_done  = o_fl_req & i_fl_ack;
   assign sign_end = (st_q == ST_SLO) & last_loc;
   assign crc_lo   = crc_step(crc_q, data_q[31:0]);

   // ------------------------------------------------------------------
   // axi4-lite write channel; aw and w accepted in either order
   // ------------------------------------------------------------------
   always_ff @(posedge i_clk or negedge rst_n)
      if (!rst_n)
      begin
         aw_ok_q      <= 1'b0;
         w_ok_q       <= 1'b0;
         wa_q         <= 6'h00;
         wd_q         <= 32'h00000000;
         ws_q         <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= 2'h0;
      end
      else
      begin
         if (s_axi_awvalid & s_axi_awready)
         begin
            aw_ok_q <= 1'b1;
            wa_q    <= {s_axi_awaddr[5:2], 2'h0};
         end
         if (s_axi_wvalid & s_axi_wready)
         begin
            w_ok_q <= 1'b1;
            wd_q   <= s_axi_wdata;
            ws_q   <= s_axi_wstrb;
         end
         if (aw_ok_q & w_ok_q & ~s_axi_bvalid)
         begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (wa_q > `FPS_OFF_WDHI) ? 2'h2 : 2'h0;
         end
         if (s_axi_bvalid & s_axi_bready)
         begin
            s_axi_bvalid <= 1'b0;
            aw_ok_q      <= 1'b0;
            w_ok_q       <= 1'b0;
         end
      end
   assign s_axi_awready = ~aw_ok_q;
   assign s_axi_wready  = ~w_ok_q;

   // ------------------------------------------------------------------
   // axi4-lite read channel
   // ------------------------------------------------------------------
   always_ff @(posedge i_clk or negedge rst_n)
      if (!rst_n)
      begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h00000000;
         s_axi_rresp  <= 2'h0;
      end
      else if (s_axi_rvalid)
      begin
         if (s_axi_rready)
            s_axi_rvalid <= 1'b0;
      end
      else if (s_axi_arvalid)
      begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp  <= 2'h0;
         case ({s_axi_araddr[5:2], 2'h0})
            `FPS_OFF_KEY:    s_axi_rdata <= {31'h0, key_ok_q};
            `FPS_OFF_PROT0:  s_axi_rdata <= prot_q[0];
            `FPS_OFF_PROT1:  s_axi_rdata <= prot_q[1];
            `FPS_OFF_SETUP:  s_axi_rdata <= setup_q;
            `FPS_OFF_STATUS: s_axi_rdata <= status_q;
            `FPS_OFF_SSTART: s_axi_rdata <= sstart_q;
            `FPS_OFF_SEND:   s_axi_rdata <= send_q;
            `FPS_OFF_SIG:    s_axi_rdata <= {8'h00, sig_q};
            `FPS_OFF_CMD:    s_axi_rdata <= 32'h00000000;
            `FPS_OFF_WADDR:  s_axi_rdata <= waddr_q;
            `FPS_OFF_WDLO:   s_axi_rdata <= wdat_q[31:0];
            `FPS_OFF_WDHI:   s_axi_rdata <= wdat_q[63:32];
            default:
            begin
               s_axi_rdata <= 32'h00000000;
               s_axi_rresp <= 2'h2;
            end
         endcase
      end
   assign s_axi_arready = ~s_axi_rvalid;

   // ------------------------------------------------------------------
   // plain registers and user key
   // ------------------------------------------------------------------
   always_ff @(posedge i_clk or negedge rst_n)
      if (!rst_n)
      begin
         setup_q  <= `FPS_SETUP_RST;
         sstart_q <= 32'h00000000;
         send_q   <= 32'h00000000;
         waddr_q  <= 32'h00000000;
         wdat_q   <= 64'h0;
         key_ok_q <= 1'b0;
      end
      else if (wr_fire)
         case (wa_q)
            `FPS_OFF_KEY:    key_ok_q <= wd_q == `FPS_USER_KEY;
            `FPS_OFF_PROT0,
            `FPS_OFF_PROT1,
            `FPS_OFF_CMD:    key_ok_q <= 1'b0;
            `FPS_OFF_SETUP:  setup_q  <= wd_q;
            `FPS_OFF_SSTART: sstart_q <= wd_q;
            `FPS_OFF_SEND:   send_q   <= wd_q;
            `FPS_OFF_WADDR:  waddr_q  <= wd_q;
            `FPS_OFF_WDLO:   wdat_q[31:0]  <= wd_q;
            `FPS_OFF_WDHI:   wdat_q[63:32] <= wd_q;
            default:         key_ok_q <= key_ok_q;
         endcase

   // ------------------------------------------------------------------
   // protection copies; only a reset reloads them
   // ------------------------------------------------------------------
   always_ff @(posedge i_clk or negedge rst_n)
      if (!rst_n)
      begin
         prot_q[0] <= `FPS_PROT_RST;
         prot_q[1] <= `FPS_PROT_RST;
         prog_q    <= 2'h0;
      end
      else if (st_q == ST_LD && fl_done)
      begin
         prot_q[ld_blk_q] <= i_fl_rdata[31:0];
         prog_q[ld_blk_q] <= i_fl_rdata[31:0] != `FPS_PROT_RST;
      end
      else if (wr_fire && key_ok_q && (wa_q == `FPS_OFF_PROT0 ||
               wa_q == `FPS_OFF_PROT1))
      begin
         if (!prog_q[wa_q[3]])
            prot_q[wa_q[3]] <= wd_q;
      end
      else if (st_q == ST_OP && fl_done)
      begin
         // erase frees the word but leaves the live copy
         if (o_fl_op == OP_EMASS ||
             (o_fl_op == OP_EPAGE && &o_fl_addr[18:13]))
            prog_q[o_fl_addr[19]] <= 1'b0;
         else if (o_fl_op == OP_WRITE &&
                  o_fl_addr[18:3] == `FPS_PW_OFF >> 3)
            prog_q[o_fl_addr[19]] <= 1'b1;
      end

   // ------------------------------------------------------------------
   // sequencer: load, sign, flash commands
   // ------------------------------------------------------------------
   always_ff @(posedge i_clk or negedge rst_n)
      if (!rst_n)
      begin
         st_q     <= ST_LD;
         ld_blk_q <= 1'b0;
         por_q    <= 1'b0;
         o_fl_req <= 1'b0;
         o_fl_op  <= OP_READ;
         o_fl_addr <= 20'h00000;
         o_fl_wdata <= 64'h0;
         cur_q    <= 20'h00000;
         last_q   <= 20'h00000;
         data_q   <= 64'h0;
         crc_q    <= `FPS_CRC_INIT;
         sig_q    <= 24'h000000;
         ecc_c_q  <= 1'b0;
         ecc_u_q  <= 1'b0;
      end
      else
         case (st_q)
            ST_LD:
            begin
               o_fl_req  <= ~fl_done;
               o_fl_op   <= OP_READ;
               o_fl_addr <= {ld_blk_q, `FPS_PW_OFF};
               if (fl_done)
               begin
                  ld_blk_q <= 1'b1;
                  if (ld_blk_q)
                  begin
                     cur_q  <= `FPS_KSIGN_START;
                     last_q <= `FPS_KSIGN_END;
                     por_q  <= 1'b1;
                     crc_q  <= `FPS_CRC_INIT;
                     st_q   <= ST_SRD;
                  end
               end
            end
            ST_IDLE:
               if (cmd_go && !f_key && !f_prot)
               begin
                  por_q      <= 1'b0;
                  o_fl_addr  <= waddr_q[19:0];
                  o_fl_wdata <= wdat_q;
                  ecc_c_q    <= 1'b0;
                  ecc_u_q    <= 1'b0;
                  crc_q      <= `FPS_CRC_INIT;
                  cur_q      <= {sstart_q[19:10], 10'h000};
                  last_q     <= {send_q[19:10], 10'h3ff};
                  case (cmd_w)
                     CMD_SIGN:  st_q <= ST_SRD;
                     CMD_WRITE: o_fl_op <= OP_WRITE;
                     CMD_EPAGE: o_fl_op <= OP_EPAGE;
                     default:   o_fl_op <= OP_EMASS;
                  endcase
                  if (cmd_w != CMD_SIGN)
                  begin
                     o_fl_req <= 1'b1;
                     st_q     <= ST_OP;
                  end
               end
            ST_SRD:
            begin
               o_fl_req  <= ~fl_done;
               o_fl_op   <= OP_READ;
               o_fl_addr <= cur_q;
               if (fl_done)
               begin
                  data_q  <= i_fl_rdata;
                  ecc_c_q <= ecc_c_q | i_fl_ecc_corr;
                  ecc_u_q <= ecc_u_q | i_fl_ecc_uncorr;
                  st_q    <= ST_SLO;
               end
            end
            ST_SLO:
            begin
               crc_q <= crc_lo;
               if (last_loc)
               begin
                  // upper word of the last location is the expectation
                  sig_q  <= crc_lo;
                  st_q   <= ST_IDLE;
               end
               else
                  st_q <= ST_SHI;
            end
            ST_SHI:
            begin
               crc_q <= crc_step(crc_q, data_q[63:32]);
               cur_q <= cur_q + 20'h00008;
               st_q  <= ST_SRD;
            end
            ST_OP:
               if (fl_done)
               begin
                  o_fl_req <= 1'b0;
                  st_q     <= ST_IDLE;
               end
            default: st_q <= ST_IDLE;
         endcase

   // ------------------------------------------------------------------
   // status; hardware set wins over software clear (write one)
   // ------------------------------------------------------------------
   logic [31:0] st_set, st_clr;
   always_comb
   begin
      st_set = 32'h00000000;
      st_set[`FPS_ST_DONE]  = sign_end | (st_q == ST_OP & fl_done);
      st_set[`FPS_ST_SFAIL] = sign_end & (crc_lo != data_q[55:32]);
      st_set[`FPS_ST_ECOR]  = sign_end & ecc_c_q;
      st_set[`FPS_ST_EUNC]  = sign_end & ecc_u_q;
      st_set[`FPS_ST_FKEY]  = cmd_go & f_key;
      st_set[`FPS_ST_FPROT] = cmd_go & ~f_key & f_prot;
      st_clr = (wr_fire && wa_q == `FPS_OFF_STATUS) ? wd_q : 32'h0;
   end
   always_ff @(posedge i_clk or negedge rst_n)
      if (!rst_n)
         status_q <= 32'h00000000;
      else
      begin
         status_q <= (status_q & ~st_clr & 32'h0000007e) | st_set;
         status_q[`FPS_ST_BUSY]  <= (st_q != ST_IDLE) & ~sign_end
                                    & ~(st_q == ST_OP & fl_done);
         status_q[`FPS_ST_FETCH] <= o_fetch_err;
      end

   // ------------------------------------------------------------------
   // stall, fetch fault and debug lock
   // ------------------------------------------------------------------
   always_ff @(posedge i_clk or negedge rst_n)
      if (!rst_n)
      begin
         o_blk_stall <= 2'h0;
         o_fetch_err <= 1'b0;
         o_dbg_wr_en <= 1'b0;
         o_dbg_rdata <= 32'h00000000;
      end
      else
      begin
         o_blk_stall <= {sgn & ~sign_end & cur_q[19],
                         sgn & ~sign_end & ~cur_q[19]};
         if (sign_end & por_q & ecc_u_q)
            o_fetch_err <= 1'b1;
         o_dbg_wr_en <= i_dbg_wr & setup_q[`FPS_SETUP_DBG];
         o_dbg_rdata <= setup_q[`FPS_SETUP_DBG] ? i_dbg_rdata : 32'h0;
      end

   // ------------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------------
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!rst_n);

   property p_key_clr;
      cmd_go |=> !key_ok_q;
   endproperty
   a_key_clr: assert property (p_key_clr)
      else $error("key not cleared by command");
   property p_nokey;
      wr_fire && wa_q == `FPS_OFF_PROT0 && !key_ok_q |=> $stable(prot_q[0]);
   endproperty
   a_nokey: assert property (p_nokey)
      else $error("protection written without key");
   property p_prog_lock;
      wr_fire && wa_q == `FPS_OFF_PROT1 && prog_q[1] && st_q == ST_IDLE
      |=> $stable(prot_q[1]);
   endproperty
   a_prog_lock: assert property (p_prog_lock)
      else $error("programmed protection copy changed");
   property p_fail_key;
      cmd_go && !key_ok_q |=> status_q[`FPS_ST_FKEY];
   endproperty
   a_fail_key: assert property (p_fail_key)
      else $error("missing key not flagged");
   property p_wr_prot;
      o_fl_req && o_fl_op == OP_WRITE |-> prot_q[o_fl_addr[19]][o_fl_addr[18:14]];
   endproperty
   a_wr_prot: assert property (p_wr_prot)
      else $error("write into protected group");
   property p_lo_hi;
      st_q == ST_SLO && !last_loc |=> st_q == ST_SHI ##1 st_q == ST_SRD;
   endproperty
   a_lo_hi: assert property (p_lo_hi)
      else $error("halves out of order");
   property p_sig;
      sign_end |=> sig_q == $past(crc_lo) && status_q[`FPS_ST_DONE];
   endproperty
   a_sig: assert property (p_sig)
      else $error("signature not stored");
   property p_stall;
      sgn && $past(sgn) && !$past(sign_end) |-> o_blk_stall != 2'h0;
   endproperty
   a_stall: assert property (p_stall)
      else $error("block not stalled while signing");
   property p_dbg;
      !setup_q[`FPS_SETUP_DBG] ##1 !setup_q[`FPS_SETUP_DBG]
      |-> o_dbg_rdata == 32'h0 && !o_dbg_wr_en;
   endproperty
   a_dbg: assert property (p_dbg)
      else $error("debug port not locked");
   property p_busy;
      st_q == ST_SRD |=> status_q[`FPS_ST_BUSY];
   endproperty
   a_busy: assert property (p_busy)
      else $error("busy missing while signing");

   c_sign_ok:   cover property (sign_end && !por_q && crc_lo == data_q[55:32]);
   c_sign_bad:  cover property (sign_end && crc_lo != data_q[55:32]);
   c_prot_wr:   cover property (wr_fire && key_ok_q && wa_q == `FPS_OFF_PROT0);
   c_fail_prot: cover property (cmd_go && !f_key && f_prot);
endmodule
`default_nettype wire

// ===== verif/fps_flash_model.sv
`timescale 1ns/100ps
`default_nettype none
module fps_flash_model
(
   input  wire logic        i_clk,
   input  wire logic        i_req,
   input  wire logic [1:0]  i_op,
   input  wire logic [19:0] i_addr,
   input  wire logic [63:0] i_wdata,
   input  wire logic [1:0]  i_lat,
   input  wire logic [1:0]  i_ecc,
   output logic             o_ack,
   output logic [63:0]      o_rdata,
   output logic             o_corr,
   output logic             o_uncorr
);
   logic [63:0] mem [0:131071];
   logic [1:0]  cnt;
   initial
   begin
      foreach (mem[i]) mem[i] = '1;
      {o_ack, o_corr, o_uncorr, cnt, o_rdata} = '0;
   end
   always @(posedge i_clk)
   begin
      {o_ack, o_corr, o_uncorr} <= 3'h0;
      // released bus keeps toggling so stale data never passes
      o_rdata <= ~o_rdata;
      if (i_req && !o_ack)
      begin
         cnt <= cnt + 2'h1;
         if (cnt >= i_lat)
         begin
            cnt   <= 2'h0;
            o_ack <= 1'b1;
            case (i_op)
               2'h0: {o_rdata, o_uncorr, o_corr} <= {mem[i_addr[19:3]], i_ecc};
               2'h1: mem[i_addr[19:3]] <= mem[i_addr[19:3]] & i_wdata;
               2'h2: for (int j = 0; j < 1024; j++)
                  mem[{i_addr[19:13], j[9:0]}] <= '1;
               default: for (int j = 0; j < 65536; j++)
                  mem[{i_addr[19], j[15:0]}] <= '1;
            endcase
         end
      end
   end
endmodule
`default_nettype wire

// ===== verif/fps_top_bench.sv
`timescale 1ns/100ps
`default_nettype none
`include "fps_params.svh"
module fps_top_bench;
   import fps_pkg::*;
   logic        clk = 0, arst_n = 0, awv = 0, wv = 0, bq = 0, arv = 0;
   logic        rq = 0, dwr = 0, bv, rv, awr, wrd, arr, req, ack, ec, eu;
   logic        ferr, den;
   logic [5:0]  aa = 0, ra = 0;
   logic [31:0] wd = 0, rdat, drd = 0, dout;
   logic [1:0]  bresp, rresp, stall, lat = 0, ecc = 0;
   logic [19:0] fa;
   logic [63:0] fw, frd;
   fps_op_t     op;
   int          fails = 0, checked = 0;
   always #5 clk = ~clk;
   fps_top fps_top_i (.i_clk(clk), .i_arst_n(arst_n), .s_axi_awaddr(aa),
      .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
      .s_axi_wstrb(4'hf), .s_axi_wvalid(wv), .s_axi_wready(wrd),
      .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(bq),
      .s_axi_araddr(ra), .s_axi_arvalid(arv), .s_axi_arready(arr),
      .s_axi_rdata(rdat), .s_axi_rresp(rresp), .s_axi_rvalid(rv),
      .s_axi_rready(rq), .o_fl_req(req), .o_fl_op(op), .o_fl_addr(fa),
      .o_fl_wdata(fw), .i_fl_ack(ack), .i_fl_rdata(frd),
      .i_fl_ecc_corr(ec), .i_fl_ecc_uncorr(eu), .o_blk_stall(stall),
      .o_fetch_err(ferr), .i_dbg_wr(dwr), .i_dbg_rdata(drd),
      .o_dbg_wr_en(den), .o_dbg_rdata(dout));
   fps_flash_model fps_flash_model_i (.i_clk(clk), .i_req(req), .i_op(op),
      .i_addr(fa), .i_wdata(fw), .i_lat(lat), .i_ecc(ecc), .o_ack(ack),
      .o_rdata(frd), .o_corr(ec), .o_uncorr(eu));
   task automatic chk(input logic [31:0] s, e, input string n);
      checked++;
      if (s !== e)
      begin
         fails++;
         $display("FAIL %s exp %h got %h", n, e, s);
      end
   endtask
   task automatic wr(input logic [5:0] a, input logic [31:0] d);
      logic ta, tw, tb;
      {aa, wd, awv, wv, bq} <= {a, d, 3'h7};
      do
      begin
         @(negedge clk);
         {ta, tw, tb} = {awv & awr, wv & wrd, bv};
         @(posedge clk);
         if (ta) awv <= 0;
         if (tw) wv <= 0;
      end while (!tb);
      bq <= 0;
      @(posedge clk);
   endtask
   task automatic rd(input logic [5:0] a, output logic [31:0] d);
      logic ta, tb;
      {ra, arv, rq} <= {a, 2'h3};
      do
      begin
         @(negedge clk);
         {ta, tb, d} = {arv & arr, rv, rdat};
         @(posedge clk);
         if (ta) arv <= 0;
      end while (!tb);
      rq <= 0;
      @(posedge clk);
   endtask
   task automatic go(input logic [31:0] c);
      wr(`FPS_OFF_KEY, `FPS_USER_KEY);
      wr(`FPS_OFF_CMD, c);
   endtask
   task automatic idle;
      logic [31:0] v;
      do rd(`FPS_OFF_STATUS, v); while (v[0] !== 1'b0);
   endtask
   task automatic rst(input logic [1:0] e);
      @(posedge clk);
      ecc <= e;
      arst_n <= 0;
      repeat (5) @(posedge clk);
      arst_n <= 1;
      repeat (5) @(posedge clk);
      idle();
   endtask
   function automatic logic [23:0] crc(input int s, e);
      logic [23:0] c;
      logic [63:0] w;
      c = `FPS_CRC_INIT;
      for (int a = s & ~'h3ff; a <= (e | 'h3ff) - 7; a += 8)
      begin
         w = fps_flash_model_i.mem[a >> 3];
         for (int i = 63; i >= 0; i--)
            if (a < (e | 'h3ff) - 7 || i >= 32)
               c = {c[22:0], 1'b0} ^ ((c[23] ^ w[{i[5] ^ 1'b1, i[4:0]}])
                  ? `FPS_CRC_POLY : 24'h0);
      end
      return c;
   endfunction
   task automatic final_report;
      $display("checked %0d fails %0d", checked, fails);
      if (fails == 0 && checked > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   initial
   begin
      #400000;
      fails++;
      final_report();
   end
   initial
   begin
      logic [31:0] v;
      logic [23:0] c;
      #1;
      c = crc(0, 'h1fff);
      fps_flash_model_i.mem['h3ff][55:32] = c;
      fps_flash_model_i.mem['h1fffe] = 64'hffffffff7fffffff;
      rst(2'h1);
      rd(`FPS_OFF_STATUS, v); chk(v[4:2], 3'h2, "post");
      chk(ferr, 0, "ferr");
      rd(`FPS_OFF_SIG, v); chk(v, c, "ksig");
      rd(`FPS_OFF_PROT1, v); chk(v, 'h7fffffff, "p1");
      $display("test power-on done");
      ecc <= 0;
      wr(`FPS_OFF_PROT0, 'hfffffffe);
      rd(`FPS_OFF_PROT0, v); chk(v, '1, "nokey");
      wr(`FPS_OFF_KEY, `FPS_USER_KEY);
      wr(`FPS_OFF_PROT0, 'hfffffffe);
      rd(`FPS_OFF_PROT0, v); chk(v, 'hfffffffe, "p0");
      rd(`FPS_OFF_KEY, v); chk(v, 0, "key");
      wr(`FPS_OFF_KEY, `FPS_USER_KEY); wr(`FPS_OFF_PROT1, 0);
      rd(`FPS_OFF_PROT1, v); chk(v, 'h7fffffff, "p1w");
      {v, c} = 0;
      wr(`FPS_OFF_WDLO, 0); wr(`FPS_OFF_WDHI, 0);
      wr(`FPS_OFF_WADDR, 'h100); go(2); idle();
      rd(`FPS_OFF_STATUS, v); chk(v[6], 1, "prot");
      chk(fps_flash_model_i.mem['h20][31:0], '1, "g0");
      wr(`FPS_OFF_WADDR, 'h4000); go(2); idle();
      chk(fps_flash_model_i.mem['h800][31:0], 0, "g1");
      wr(`FPS_OFF_WADDR, 'h7fff0); wr(`FPS_OFF_CMD, 2); idle();
      rd(`FPS_OFF_STATUS, v); chk(v[5], 1, "pwkey");
      wr(`FPS_OFF_STATUS, 'h7e); wr(`FPS_OFF_WADDR, 'hfe000);
      go(3); idle();
      rd(`FPS_OFF_STATUS, v); chk(v[6], 1, "epage");
      wr(`FPS_OFF_WADDR, 'h80000); go(4); idle();
      rd(`FPS_OFF_PROT1, v); chk(v, 'h7fffffff, "keep");
      wr(`FPS_OFF_KEY, `FPS_USER_KEY); wr(`FPS_OFF_PROT1, 0);
      rd(`FPS_OFF_PROT1, v); chk(v, 0, "p1e");
      $display("test protect done");
      lat <= 1;
      for (int a = 'h800; a < 'h900; a++)
         fps_flash_model_i.mem[a] = {a, ~a};
      c = crc('h4123, 'h4400);
      fps_flash_model_i.mem['h8ff][55:32] = c;
      for (int k = 0; k < 2; k++)
      begin
         wr(`FPS_OFF_STATUS, 'h7e);
         wr(`FPS_OFF_SSTART, 'h4123);
         wr(`FPS_OFF_SEND, 'h4400); go(1);
         repeat (3) @(posedge clk);
         @(negedge clk);
         chk(stall, 1, "stall");
         @(posedge clk);
         rd(`FPS_OFF_STATUS, v); chk(v[0], 1, "busy");
         idle();
         rd(`FPS_OFF_SIG, v); chk(v, c, "sig");
         rd(`FPS_OFF_STATUS, v); chk(v[2], k, "sfail");
         fps_flash_model_i.mem['h8ff][55:32] = ~c;
      end
      $display("test sign done");
      {dwr, drd} <= 33'h15a5aa5a5;
      repeat (2) @(posedge clk);
      @(negedge clk);
      chk(den, 1, "dbgwr");
      chk(dout, 'h5a5aa5a5, "dbgrd");
      @(posedge clk);
      wr(`FPS_OFF_SETUP, 0); chk(bresp, 0, "bokay");
      repeat (2) @(posedge clk);
      @(negedge clk);
      chk(den, 0, "lockwr");
      chk(dout, 0, "lockrd");
      @(posedge clk);
      rd(6'h30, v); chk(rresp, 2, "slverr");
      wr(6'h30, 0); chk(bresp, 2, "bslverr");
      $display("test debug done");
      rst(2'h2);
      chk(ferr, 1, "fetch");
      $display("test uncorr done");
      final_report();
   end
endmodule
`default_nettype wire
